/* design/mot_params.svh */
// constants of the payload octet counters and arrival time stamping
// Summary of operation
// - keep separate 64-bit running payload byte totals for receive and transmit
// - only frames free of FCS, oversize, undersize and length errors qualify
// - each direction gives a 16-bit per-frame payload count with a valid pulse
// - the per-frame count means something only while its valid pulse is high
// - per-frame counts and pulses work even with the running totals left out
// - receive and transmit signals all follow the one shared clock, ref_clk_i
// - with time option on, every received packet gets a wide and/or narrow stamp
// - the receive stamp is valid in the same cycle as client start-of-packet
// - the receive stamp is the time sampled at link arrival, not at delivery
// - a fingerprint given with a timing packet comes back unchanged
// - outgoing timing packets get exit time updates, one-step or two-step
`ifndef MOT_PARAMS_SVH
`define MOT_PARAMS_SVH

`define MOT_LEN_W          16
`define MOT_TOTAL_W        64
`define MOT_WIDE_W         96
`define MOT_NARROW_W       64
`define MOT_FP_W           8
`define MOT_TOTAL_RST      64'h0
`define MOT_LEN_RST        16'h0
// wide format field positions (seconds, nanoseconds, fraction) and the narrow nanoseconds position
`define MOT_WIDE_SEC_LSB   48
`define MOT_WIDE_NS_LSB    16
`define MOT_NARROW_NS_LSB  16
`define MOT_NS_PER_SEC     33'h03b9aca00
// fixed transit latency of the transmit path, in nanoseconds
`define MOT_TX_LATENCY_NS  32'h00000032
`define MOT_RX_DEPTH       4

`endif

/* design/mot_payload_counter.sv */
// per-frame payload count, valid pulse and running total for one direction
`timescale 1ns/100ps
`include "mot_params.svh"
module mot_payload_counter
    import mot_pkg::*;
#(
    parameter bit TOTALS_ON = 1'b1
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    input  wire mot_frame_end_s          frame_i,
    output logic [`MOT_LEN_W-1:0]        count_o,
    output logic                         strobe_o,
    output logic [`MOT_TOTAL_W-1:0]      total_o
);
    logic [`MOT_LEN_W-1:0]   count_ff;
    logic                    strobe_ff;
    logic [`MOT_TOTAL_W-1:0] total_ff;
    logic [`MOT_LEN_W-1:0]   nxt_count;
    logic                    nxt_strobe;
    logic [`MOT_TOTAL_W-1:0] nxt_total;
    logic                    qualifies;

    // qualify the frame and work out the next count and total
    always_comb begin
        qualifies  = frame_i.done && !frame_i.fcs_err && !frame_i.oversize
                     && !frame_i.undersize && !frame_i.len_err;
        nxt_strobe = qualifies;
        nxt_count  = qualifies ? frame_i.len : count_ff;
        nxt_total  = total_ff;
        if (qualifies && TOTALS_ON) begin
            nxt_total = total_ff + {{(`MOT_TOTAL_W-`MOT_LEN_W){1'b0}}, frame_i.len};
        end
        if (!TOTALS_ON) begin
            nxt_total = `MOT_TOTAL_RST;
        end
    end

    // registers on ref_clk_i, the clock shared by both directions
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            count_ff  <= `MOT_LEN_RST;
            strobe_ff <= 1'b0;
            total_ff  <= `MOT_TOTAL_RST;
        end else begin
            count_ff  <= nxt_count;
            strobe_ff <= nxt_strobe;
            total_ff  <= nxt_total;
        end
    end

    assign count_o  = count_ff;
    assign strobe_o = strobe_ff;
    assign total_o  = total_ff;
endmodule

/* design/mot_pkg.sv */
// types shared by the payload counters and time stamping
package mot_pkg;
`include "mot_params.svh"

    // end-of-frame report from the mac datapath
    typedef struct packed {
        logic                  done;
        logic [`MOT_LEN_W-1:0] len;
        logic                  fcs_err;
        logic                  oversize;
        logic                  undersize;
        logic                  len_err;
    } mot_frame_end_s;

    typedef struct packed {
        logic [`MOT_WIDE_W-1:0]   wide;
        logic [`MOT_NARROW_W-1:0] narrow;
    } mot_stamp_s;

    typedef enum logic [1:0] {
        MOT_TX_NONE,
        MOT_TX_TWO_STEP,
        MOT_TX_INSERT,
        MOT_TX_CORRECT
    } mot_tx_mode_e;

    // request given with transmit start-of-packet
    typedef struct packed {
        logic                     sop;
        logic                     two_step;
        logic                     insert;
        logic                     correct;
        logic [`MOT_FP_W-1:0]     fingerprint;
        logic [`MOT_NARROW_W-1:0] ingress_narrow;
    } mot_tx_req_s;

    typedef struct packed {
        mot_tx_mode_e             mode;
        logic [`MOT_FP_W-1:0]     fingerprint;
        logic [`MOT_WIDE_W-1:0]   wide;
        logic [`MOT_NARROW_W-1:0] narrow;
    } mot_tx_stamp_s;
endpackage

/* design/mot_top.sv */
// payload octet counters for both directions plus receive and transmit time stamping
`timescale 1ns/100ps
`include "mot_params.svh"
module mot_top
    import mot_pkg::*;
#(
    parameter bit PRECISION_TIME_OPTION = 1'b1,
    parameter bit WIDE_ON               = 1'b1,
    parameter bit NARROW_ON             = 1'b1,
    parameter bit STATS_TOTALS_ON       = 1'b1,
    parameter int RX_DEPTH              = `MOT_RX_DEPTH
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire mot_frame_end_s           rx_frame_end_i,
    input  wire mot_frame_end_s           tx_frame_end_i,
    output logic [`MOT_LEN_W-1:0]         rx_frame_payload_count_o,
    output logic                          rx_frame_payload_count_strobe_o,
    output logic [`MOT_TOTAL_W-1:0]       rx_good_payload_total_o,
    output logic [`MOT_LEN_W-1:0]         tx_frame_payload_count_o,
    output logic                          tx_frame_payload_count_strobe_o,
    output logic [`MOT_TOTAL_W-1:0]       tx_good_payload_total_o,
    input  wire logic                     rx_link_arrival_i,
    input  wire logic                     rx_client_sop_i,
    input  wire logic [`MOT_WIDE_W-1:0]   rx_current_time_wide_i,
    input  wire logic [`MOT_NARROW_W-1:0] rx_current_time_narrow_i,
    output logic                          rx_client_sop_o,
    output logic [`MOT_WIDE_W-1:0]        rx_arrival_time_wide_o,
    output logic [`MOT_NARROW_W-1:0]      rx_arrival_time_narrow_o,
    input  wire mot_tx_req_s              tx_req_i,
    input  wire logic [`MOT_WIDE_W-1:0]   tx_current_time_wide_i,
    input  wire logic [`MOT_NARROW_W-1:0] tx_current_time_narrow_i,
    output mot_tx_stamp_s                 tx_stamp_o
);
    localparam int PW = $clog2(RX_DEPTH);

    // add the transit latency to both time formats, wrapping nanoseconds
    function automatic mot_stamp_s add_latency(input mot_stamp_s t, input logic [31:0] lat_ns);
        mot_stamp_s  r;
        logic [32:0] ns_sum;
        r      = t;
        ns_sum = {1'b0, t.wide[`MOT_WIDE_SEC_LSB-1:`MOT_WIDE_NS_LSB]} + {1'b0, lat_ns};
        if (ns_sum >= `MOT_NS_PER_SEC) begin
            ns_sum = ns_sum - `MOT_NS_PER_SEC;
            r.wide[`MOT_WIDE_W-1:`MOT_WIDE_SEC_LSB] = t.wide[`MOT_WIDE_W-1:`MOT_WIDE_SEC_LSB] + 48'h1;
        end
        r.wide[`MOT_WIDE_SEC_LSB-1:`MOT_WIDE_NS_LSB] = ns_sum[31:0];
        r.narrow = t.narrow + {16'h0, lat_ns, 16'h0};
        return r;
    endfunction

    // keep only the formats that are built in
    function automatic mot_stamp_s mask_formats(input mot_stamp_s t);
        mot_stamp_s r;
        r.wide   = WIDE_ON   ? t.wide   : '0;
        r.narrow = NARROW_ON ? t.narrow : '0;
        return r;
    endfunction

    // per-direction payload counters, both on the shared ref_clk_i
    mot_payload_counter #(
        .TOTALS_ON (STATS_TOTALS_ON)
    ) u_rx_count (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .frame_i   (rx_frame_end_i),
        .count_o   (rx_frame_payload_count_o),
        .strobe_o  (rx_frame_payload_count_strobe_o),
        .total_o   (rx_good_payload_total_o)
    );

    mot_payload_counter #(
        .TOTALS_ON (STATS_TOTALS_ON)
    ) u_tx_count (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .frame_i   (tx_frame_end_i),
        .count_o   (tx_frame_payload_count_o),
        .strobe_o  (tx_frame_payload_count_strobe_o),
        .total_o   (tx_good_payload_total_o)
    );

    // receive arrival stamp queue state
    mot_stamp_s    mem_ff [RX_DEPTH];
    mot_stamp_s    nxt_mem [RX_DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0]   fill_ff;
    logic [PW-1:0] nxt_wr;
    logic [PW-1:0] nxt_rd;
    logic [PW:0]   nxt_fill;
    logic          push;
    logic          pop;
    mot_stamp_s    now_stamp;
    mot_stamp_s    head_stamp;

    // receive client outputs
    logic                     rx_sop_ff;
    logic [`MOT_WIDE_W-1:0]   rx_wide_ff;
    logic [`MOT_NARROW_W-1:0] rx_narrow_ff;
    logic                     nxt_rx_sop;
    logic [`MOT_WIDE_W-1:0]   nxt_rx_wide;
    logic [`MOT_NARROW_W-1:0] nxt_rx_narrow;

    // sample link time, queue it, hand the oldest to the client start-of-packet
    always_comb begin
        now_stamp  = mask_formats({rx_current_time_wide_i, rx_current_time_narrow_i});
        head_stamp = (fill_ff != '0) ? mem_ff[rd_ff] : now_stamp;
        pop        = rx_client_sop_i && (fill_ff != '0);
        push       = rx_link_arrival_i && (fill_ff < (PW+1)'(RX_DEPTH))
                     && !(rx_client_sop_i && (fill_ff == '0));
        nxt_mem    = mem_ff;
        if (push) begin
            nxt_mem[wr_ff] = now_stamp;
        end
        nxt_wr        = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd        = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_fill      = fill_ff + (PW+1)'(push) - (PW+1)'(pop);
        nxt_rx_sop    = rx_client_sop_i;
        nxt_rx_wide   = rx_wide_ff;
        nxt_rx_narrow = rx_narrow_ff;
        if (rx_client_sop_i) begin
            nxt_rx_wide   = PRECISION_TIME_OPTION ? head_stamp.wide   : '0;
            nxt_rx_narrow = PRECISION_TIME_OPTION ? head_stamp.narrow : '0;
        end
    end

    // queue storage holds data only, no reset needed
    always_ff @(posedge ref_clk_i) begin
        mem_ff <= nxt_mem;
    end

    // receive control and outputs on the shared ref_clk_i
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_ff        <= '0;
            rd_ff        <= '0;
            fill_ff      <= '0;
            rx_sop_ff    <= 1'b0;
            rx_wide_ff   <= '0;
            rx_narrow_ff <= '0;
        end else begin
            wr_ff        <= nxt_wr;
            rd_ff        <= nxt_rd;
            fill_ff      <= nxt_fill;
            rx_sop_ff    <= nxt_rx_sop;
            rx_wide_ff   <= nxt_rx_wide;
            rx_narrow_ff <= nxt_rx_narrow;
        end
    end

    assign rx_client_sop_o          = rx_sop_ff;
    assign rx_arrival_time_wide_o   = rx_wide_ff;
    assign rx_arrival_time_narrow_o = rx_narrow_ff;

    // transmit stamp state
    mot_tx_stamp_s tx_ff;
    mot_tx_stamp_s nxt_tx;
    mot_stamp_s    tx_exit;

    // exit time for two-step report, one-step insert or residence correction
    always_comb begin
        tx_exit = add_latency(mask_formats({tx_current_time_wide_i, tx_current_time_narrow_i}),
                              `MOT_TX_LATENCY_NS);
        nxt_tx             = tx_ff;
        nxt_tx.mode        = MOT_TX_NONE;
        if (PRECISION_TIME_OPTION && tx_req_i.sop) begin
            nxt_tx.fingerprint = tx_req_i.fingerprint;
            nxt_tx.wide        = tx_exit.wide;
            nxt_tx.narrow      = tx_exit.narrow;
            if (tx_req_i.correct) begin
                nxt_tx.mode   = MOT_TX_CORRECT;
                nxt_tx.narrow = tx_exit.narrow - tx_req_i.ingress_narrow;
            end else if (tx_req_i.insert) begin
                nxt_tx.mode = MOT_TX_INSERT;
            end else if (tx_req_i.two_step) begin
                nxt_tx.mode = MOT_TX_TWO_STEP;
            end
        end
    end

    // transmit stamp register on the shared ref_clk_i
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_ff <= '{mode: MOT_TX_NONE, default: '0};
        end else begin
            tx_ff <= nxt_tx;
        end
    end

    assign tx_stamp_o = tx_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_rx_good_pulse: assert property (
        rx_frame_end_i.done && !rx_frame_end_i.fcs_err && !rx_frame_end_i.oversize
        && !rx_frame_end_i.undersize && !rx_frame_end_i.len_err
        |=> rx_frame_payload_count_strobe_o && rx_frame_payload_count_o == $past(rx_frame_end_i.len))
        else $error("good rx frame not reported with its length");

    a_rx_bad_frame: assert property (
        rx_frame_end_i.done && (rx_frame_end_i.fcs_err || rx_frame_end_i.oversize
        || rx_frame_end_i.undersize || rx_frame_end_i.len_err)
        |=> !rx_frame_payload_count_strobe_o && $stable(rx_good_payload_total_o))
        else $error("errored rx frame was counted");

    a_tx_strobe_cause: assert property (
        tx_frame_payload_count_strobe_o |-> $past(tx_frame_end_i.done) && !$past(tx_frame_end_i.fcs_err))
        else $error("tx strobe without a qualifying frame");

    a_rx_total_adds: assert property (
        STATS_TOTALS_ON && rx_frame_payload_count_strobe_o
        |-> rx_good_payload_total_o == $past(rx_good_payload_total_o) + 64'(rx_frame_payload_count_o))
        else $error("rx total did not advance by frame length");

    a_tx_total_hold: assert property (
        !tx_frame_payload_count_strobe_o |-> $stable(tx_good_payload_total_o))
        else $error("tx total moved without a strobe");

    a_rx_stamp_sop: assert property (
        PRECISION_TIME_OPTION && rx_client_sop_i
        |=> rx_client_sop_o && rx_arrival_time_wide_o == $past(head_stamp.wide)
            && rx_arrival_time_narrow_o == $past(head_stamp.narrow))
        else $error("rx stamp not presented with start-of-packet");

    a_rx_arrival_time: assert property (
        (PRECISION_TIME_OPTION && NARROW_ON && rx_link_arrival_i && fill_ff == '0 && !rx_client_sop_i)
        ##1 (!rx_link_arrival_i && rx_client_sop_i)
        |=> rx_arrival_time_narrow_o == $past(rx_current_time_narrow_i, 2))
        else $error("rx stamp is not the link arrival time");

    a_tx_fingerprint: assert property (
        PRECISION_TIME_OPTION && tx_req_i.sop && tx_req_i.two_step && !tx_req_i.insert && !tx_req_i.correct
        |=> tx_stamp_o.mode == MOT_TX_TWO_STEP && tx_stamp_o.fingerprint == $past(tx_req_i.fingerprint))
        else $error("fingerprint not returned with two-step stamp");

    a_tx_exit_time: assert property (
        PRECISION_TIME_OPTION && NARROW_ON && tx_req_i.sop && !tx_req_i.correct
        |=> tx_stamp_o.narrow == $past(tx_current_time_narrow_i) + {16'h0, `MOT_TX_LATENCY_NS, 16'h0})
        else $error("tx exit time wrong");
endmodule

/* dv/mot_tod_model.sv */
// free running time of day source shared by both directions
`timescale 1ns/100ps
module mot_tod_model #(
    parameter logic [31:0] START_NS = 32'h3b9ac618
) (
    input  wire logic        ref_clk_i,
    output logic [95:0]      time_wide_o,
    output logic [63:0]      time_narrow_o
);
    logic [47:0] sec_ff = 48'h0000_0000_0001;
    logic [31:0] ns_ff  = START_NS;
    logic [47:0] nsn_ff = 48'h0000_0100_0000;

    // one clock period of 10 ns added every cycle, never paused, wrap at one second
    always @(posedge ref_clk_i) begin
        if (ns_ff >= 32'h3b9ac9f6) begin
            ns_ff  <= ns_ff - 32'h3b9ac9f6;
            sec_ff <= sec_ff + 48'h1;
        end else begin
            ns_ff <= ns_ff + 32'ha;
        end
        nsn_ff <= nsn_ff + 48'ha;
    end

    // nonzero fractions catch field shifts
    assign time_wide_o   = {sec_ff, ns_ff, 16'h0abc};
    assign time_narrow_o = {nsn_ff, 16'h1234};
endmodule

/* dv/tb_mac_octet_count_rx_timestamp.sv */
// self-checking testbench for payload counters and time stamping
`timescale 1ns/100ps
`include "mot_params.svh"
module tb_mac_octet_count_rx_timestamp;
    import mot_pkg::*;
    logic                     clk;
    logic                     rst_n;
    mot_frame_end_s           rx_fe;
    mot_frame_end_s           tx_fe;
    logic                     rx_arr;
    logic                     rx_sop;
    mot_tx_req_s              tx_req;
    logic [`MOT_WIDE_W-1:0]   tod_w;
    logic [`MOT_NARROW_W-1:0] tod_n;
    logic [`MOT_LEN_W-1:0]    rx_cnt;
    logic                     rx_stb;
    logic [`MOT_TOTAL_W-1:0]  rx_tot;
    logic [`MOT_LEN_W-1:0]    tx_cnt;
    logic                     tx_stb;
    logic [`MOT_TOTAL_W-1:0]  tx_tot;
    logic                     sop_o;
    logic [`MOT_WIDE_W-1:0]   st_w;
    logic [`MOT_NARROW_W-1:0] st_n;
    mot_tx_stamp_s            tx_st;
    logic [`MOT_LEN_W-1:0]    l_rx_cnt;
    logic                     l_rx_stb;
    logic [`MOT_TOTAL_W-1:0]  l_rx_tot;
    logic                     l_sop_o;
    logic [`MOT_WIDE_W-1:0]   l_st_w;
    logic [`MOT_NARROW_W-1:0] l_st_n;
    mot_tx_stamp_s            l_tx_st;
    logic [`MOT_TOTAL_W-1:0]  er;
    logic [`MOT_TOTAL_W-1:0]  et;
    int                       bad_count = 0;
    int                       n_tests = 0;

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    mot_tod_model u_tod (.ref_clk_i(clk), .time_wide_o(tod_w), .time_narrow_o(tod_n));

    mot_top u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .rx_frame_end_i(rx_fe), .tx_frame_end_i(tx_fe),
        .rx_frame_payload_count_o(rx_cnt), .rx_frame_payload_count_strobe_o(rx_stb),
        .rx_good_payload_total_o(rx_tot), .tx_frame_payload_count_o(tx_cnt),
        .tx_frame_payload_count_strobe_o(tx_stb), .tx_good_payload_total_o(tx_tot),
        .rx_link_arrival_i(rx_arr), .rx_client_sop_i(rx_sop), .rx_current_time_wide_i(tod_w),
        .rx_current_time_narrow_i(tod_n), .rx_client_sop_o(sop_o), .rx_arrival_time_wide_o(st_w),
        .rx_arrival_time_narrow_o(st_n), .tx_req_i(tx_req), .tx_current_time_wide_i(tod_w),
        .tx_current_time_narrow_i(tod_n), .tx_stamp_o(tx_st)
    );

    // second copy with time option and running totals left out
    mot_top #(.PRECISION_TIME_OPTION(1'b0), .STATS_TOTALS_ON(1'b0)) u_dut_lite (
        .ref_clk_i(clk), .rst_n_i(rst_n), .rx_frame_end_i(rx_fe), .tx_frame_end_i(tx_fe),
        .rx_frame_payload_count_o(l_rx_cnt), .rx_frame_payload_count_strobe_o(l_rx_stb),
        .rx_good_payload_total_o(l_rx_tot), .tx_frame_payload_count_o(),
        .tx_frame_payload_count_strobe_o(), .tx_good_payload_total_o(),
        .rx_link_arrival_i(rx_arr), .rx_client_sop_i(rx_sop), .rx_current_time_wide_i(tod_w),
        .rx_current_time_narrow_i(tod_n), .rx_client_sop_o(l_sop_o), .rx_arrival_time_wide_o(l_st_w),
        .rx_arrival_time_narrow_o(l_st_n), .tx_req_i(tx_req), .tx_current_time_wide_i(tod_w),
        .tx_current_time_narrow_i(tod_n), .tx_stamp_o(l_tx_st)
    );

    // compare and count
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hold reset 8 cycles, then the main copy's outputs, apart from the transmit stamp times, must read idle
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        er = '0;
        et = '0;
        check(rx_stb, 1'b0);
        check(tx_stb, 1'b0);
        check(rx_tot, er);
        check(tx_tot, et);
        check({rx_cnt, tx_cnt, sop_o}, '0);
        check(st_w, '0);
        check({st_n, tx_st.fingerprint}, '0);
        check(tx_st.mode, MOT_TX_NONE);
        $display("reset test done");
    endtask

    // back to back frames, every error flag once, boundary lengths
    task automatic test_frames();
        logic [`MOT_LEN_W-1:0] lens [8];
        logic [3:0]            errs [8];
        logic [`MOT_LEN_W-1:0] ecr;
        logic [`MOT_LEN_W-1:0] ect;
        logic                  good;
        lens = '{16'h0040, 16'hffff, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0001, 16'h05dc};
        errs = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0};
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk);
            rx_fe <= (i < 8) ? {1'b1, lens[i], errs[i]} : '0;
            tx_fe <= (i < 8) ? {1'b1, lens[i] ^ 16'h0003, errs[i]} : '0;
            @(negedge clk);
            if (i > 0) begin
                good = (errs[i-1] == 4'h0);
                if (good) begin
                    er  = er + lens[i-1];
                    et  = et + (lens[i-1] ^ 16'h0003);
                    ecr = lens[i-1];
                    ect = lens[i-1] ^ 16'h0003;
                end
                check(rx_stb, good);
                check(tx_stb, good);
                check(rx_tot, er);
                check(tx_tot, et);
                check({l_rx_stb, l_rx_tot}, {good, 64'h0});
                if (good) begin
                    check(l_rx_cnt, ecr);
                    check(rx_cnt, ecr);
                    check(tx_cnt, ect);
                end
            end
        end
        $display("frame count test done");
    endtask

    // two queued arrivals, delayed back to back sops, then arrival with sop
    task automatic test_rx_stamp();
        logic [`MOT_WIDE_W-1:0]   w0, w1, w2;
        logic [`MOT_NARROW_W-1:0] n0, n1, n2;
        @(posedge clk);
        rx_arr <= 1'b1;
        @(negedge clk);
        w0 = tod_w;
        n0 = tod_n;
        @(posedge clk);
        @(negedge clk);
        w1 = tod_w;
        n1 = tod_n;
        @(posedge clk);
        rx_arr <= 1'b0;
        repeat (3) @(posedge clk);
        rx_sop <= 1'b1;
        @(negedge clk);
        check(sop_o, 1'b0);
        @(posedge clk);
        @(negedge clk);
        check({sop_o, st_n}, {1'b1, n0});
        check(st_w, w0);
        @(posedge clk);
        rx_arr <= 1'b1;
        @(negedge clk);
        check({sop_o, st_n}, {1'b1, n1});
        check(st_w, w1);
        w2 = tod_w;
        n2 = tod_n;
        @(posedge clk);
        rx_arr <= 1'b0;
        rx_sop <= 1'b0;
        @(negedge clk);
        check({sop_o, st_n}, {1'b1, n2});
        check(st_w, w2);
        @(posedge clk);
        @(negedge clk);
        check({sop_o, st_n}, {1'b0, n2});
        // arrival then start-of-packet on the very next cycle
        @(posedge clk);
        rx_arr <= 1'b1;
        @(negedge clk);
        w0 = tod_w;
        n0 = tod_n;
        @(posedge clk);
        rx_arr <= 1'b0;
        rx_sop <= 1'b1;
        @(posedge clk);
        rx_sop <= 1'b0;
        @(negedge clk);
        check({sop_o, st_n}, {1'b1, n0});
        check(st_w, w0);
        check({l_sop_o, l_st_n}, {1'b1, 64'h0});
        check(l_st_w, '0);
        $display("receive stamp test done");
    endtask

    // every transmit mode and the priority case, crossing a second boundary
    task automatic test_tx_stamp();
        logic [2:0]               fl [5];
        mot_tx_mode_e             em [5];
        logic [`MOT_NARROW_W-1:0] n, en;
        logic [`MOT_WIDE_W-1:0]   w, ew;
        logic [32:0]              ns;
        fl = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b111};
        em = '{MOT_TX_TWO_STEP, MOT_TX_INSERT, MOT_TX_CORRECT, MOT_TX_NONE, MOT_TX_CORRECT};
        for (int g = 0; g < 300 && tod_w[47:16] < 32'h3b9ac9b0; g++) @(negedge clk);
        if (tod_w[47:16] < 32'h3b9ac9b0) begin
            bad_count++;
            wrap_up();
        end
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            tx_req <= {1'b1, fl[i], 8'h5a + 8'(i), 64'h0000_0123_4567_0000};
            @(negedge clk);
            w = tod_w;
            n = tod_n;
            @(posedge clk);
            tx_req.sop <= 1'b0;
            @(negedge clk);
            ns = {1'b0, w[47:16]} + `MOT_TX_LATENCY_NS;
            if (ns >= `MOT_NS_PER_SEC) begin
                ew = {w[95:48] + 48'h1, 32'(ns - `MOT_NS_PER_SEC), w[15:0]};
            end else begin
                ew = {w[95:48], ns[31:0], w[15:0]};
            end
            en = n + {`MOT_TX_LATENCY_NS, 16'h0000};
            if (em[i] == MOT_TX_CORRECT) begin
                en = en - 64'h0000_0123_4567_0000;
            end
            check(tx_st.mode, em[i]);
            check(tx_st.fingerprint, 8'h5a + 8'(i));
            check(tx_st.wide, ew);
            check(tx_st.narrow, en);
            check({l_tx_st.mode, l_tx_st.fingerprint}, '0);
        end
        @(negedge clk);
        check(tx_st.mode, MOT_TX_NONE);
        check(tx_st.fingerprint, 8'h5e);
        $display("transmit stamp test done");
    endtask

    // hang guard
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    // main sequence, ending with a reset in mid-run
    initial begin
        rst_n  = 1'b0;
        rx_fe  = '0;
        tx_fe  = '0;
        rx_arr = 1'b0;
        rx_sop = 1'b0;
        tx_req = '0;
        do_reset();
        test_frames();
        test_rx_stamp();
        test_tx_stamp();
        do_reset();
        wrap_up();
    end
endmodule
